// ### design/pms_pkg.sv
// constants for the pci mode and reset strap loader
// Notes on behaviour
// - config cycles answered only in agent mode
// - host mode: pci reaches embedded registers only
// - agent mode decodes inbound and outbound windows
// - strap low selects hold 000, else 110
package pms_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PLL_W = 4;
   localparam int HOLD_W = 3;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_IN_BASE = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_IN_MASK = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_OUT_BASE = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_OUT_MASK = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_MBOX = 12'h100;
   // offsets at or above this belong to embedded functions
   localparam logic [ADDR_W-1:0] EMB_FIRST = 12'h100;
   // status fields
   localparam int ST_HOST = 0;
   localparam int ST_VALID = 1;
   localparam int ST_PLL_LSB = 4;
   localparam int ST_HOLD_LSB = 8;
   // window base bit 0 enables the window
   localparam int WIN_EN = 0;
   // hold settings
   localparam logic [HOLD_W-1:0] HOLD_FAST = 3'h0;
   localparam logic [HOLD_W-1:0] HOLD_DEFAULT = 3'h6;
   // reset values
   localparam logic [PLL_W-1:0] PLL_RST = 4'h0;
   localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
   // memory space base of the register block as seen from pci
   localparam logic [DATA_W-1:0] REG_BAR = 32'h8000_0000;
   localparam logic [DATA_W-1:0] REG_BAR_MASK = 32'hffff_f000;
endpackage

// ### design/pms_bridge.sv
// pci mode, strap capture and window decode of the bridge
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
module pms_bridge (
   input wire logic clk_i,
   input wire logic resetn_i,
   // board pins
   input wire logic hard_reset_in_n_i,
   input wire logic host_mode_i,
   input wire logic [pms_pkg::PLL_W-1:0] pll_code_i,
   input wire logic mem_addr4_strap_i,
   // captured configuration
   output logic cfg_valid_o,
   output logic host_mode_o,
   output logic [pms_pkg::PLL_W-1:0] pll_code_o,
   output logic [pms_pkg::HOLD_W-1:0] pci_hold_o,
   // local register port
   input wire logic [pms_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [pms_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [pms_pkg::DATA_W-1:0] reg_rdata_o,
   // pci target request, same clock
   input wire logic pci_req_i,
   input wire logic pci_cfg_i,
   input wire logic pci_idsel_i,
   input wire logic pci_wr_i,
   input wire logic [pms_pkg::DATA_W-1:0] pci_addr_i,
   input wire logic [pms_pkg::DATA_W-1:0] pci_wdata_i,
   output logic pci_ack_o,
   output logic pci_in_hit_o,
   output logic [pms_pkg::DATA_W-1:0] pci_rdata_o,
   // local outbound request
   input wire logic out_req_i,
   input wire logic [pms_pkg::DATA_W-1:0] out_addr_i,
   output logic out_hit_o
);
   import pms_pkg::*;

   // ****************************************
   // elaboration checks
   // ****************************************
   // status fields must fit the word and stay apart
   if (ST_HOLD_LSB + HOLD_W > DATA_W || ST_PLL_LSB + PLL_W > ST_HOLD_LSB) begin : g_bad_status
      $error("status fields do not fit the register word");
   end
   if (ST_VALID <= ST_HOST || ST_PLL_LSB <= ST_VALID) begin : g_bad_order
      $error("status flag positions overlap");
   end
   // embedded area must sit above the standard registers
   if (EMB_FIRST <= OFF_OUT_MASK || OFF_MBOX < EMB_FIRST) begin : g_bad_map
      $error("embedded area overlaps the standard registers");
   end
   // register block must fit the decoded pci window
   if (ADDR_W > DATA_W || (REG_BAR & ~REG_BAR_MASK) != WORD_RST) begin : g_bad_bar
      $error("register window is not aligned to its size");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int PW = 3 + PLL_W;
   logic [PW-1:0] s1_r, s2_r, s3_r;
   logic [PW-1:0] pins;
   logic hrst_n_r;
   logic [PW-1:0] pin_lvl_r;

   assign pins = {hard_reset_in_n_i, host_mode_i, mem_addr4_strap_i, pll_code_i};

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes once second and third stage agree
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_lvl_r <= '0;
      end else begin
         for (int i = 0; i < PW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               pin_lvl_r[i] <= s3_r[i];
            end
         end
      end
   end

   logic hrst_n_lvl, host_lvl, addr4_lvl, release_ev;
   logic [PLL_W-1:0] pll_lvl;
   assign hrst_n_lvl = pin_lvl_r[PW-1];
   assign host_lvl = pin_lvl_r[PW-2];
   assign addr4_lvl = pin_lvl_r[PW-3];
   assign pll_lvl = pin_lvl_r[PLL_W-1:0];
   assign release_ev = hrst_n_lvl && !hrst_n_r;

   // ****************************************
   // strap capture
   // ****************************************
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hrst_n_r <= 1'b0;
         cfg_valid_o <= 1'b0;
         host_mode_o <= 1'b0;
         pll_code_o <= PLL_RST;
         pci_hold_o <= HOLD_DEFAULT;
      end else begin
         hrst_n_r <= hrst_n_lvl;
         if (!hrst_n_lvl) begin
            cfg_valid_o <= 1'b0;
         end else if (release_ev) begin
            cfg_valid_o <= 1'b1;
            host_mode_o <= host_lvl;
            pll_code_o <= pll_lvl;
            pci_hold_o <= addr4_lvl ? HOLD_DEFAULT : HOLD_FAST;
         end
      end
   end

   // ****************************************
   // registers and access decode
   // ****************************************
   logic [DATA_W-1:0] in_base_r, in_mask_r, out_base_r, out_mask_r, mbox_r;
   logic agent, pci_is_reg, pci_allowed, pci_reg_wr, pci_emb;
   logic [ADDR_W-1:0] pci_off;
   logic in_hit, out_hit;
   logic [DATA_W-1:0] status_w;

   assign agent = cfg_valid_o && !host_mode_o;
   assign pci_off = pci_addr_i[ADDR_W-1:0];
   assign pci_emb = pci_off >= EMB_FIRST;
   // config cycles need agent mode and device select
   assign pci_is_reg = pci_cfg_i ? (agent && pci_idsel_i)
                     : (cfg_valid_o && ((pci_addr_i & REG_BAR_MASK) == REG_BAR));
   // host mode limits pci to embedded functions
   assign pci_allowed = pci_req_i && pci_is_reg && (agent || pci_emb);
   assign pci_reg_wr = pci_allowed && pci_wr_i;

   assign in_hit = agent && in_base_r[WIN_EN] && !pci_cfg_i && !pci_is_reg
                 && ((pci_addr_i & in_mask_r) == (in_base_r & in_mask_r));
   assign out_hit = agent && out_base_r[WIN_EN]
                  && ((out_addr_i & out_mask_r) == (out_base_r & out_mask_r));

   // fields placed by position, unused bits read as zero
   always_comb begin
      status_w = WORD_RST;
      status_w[ST_HOST] = host_mode_o;
      status_w[ST_VALID] = cfg_valid_o;
      status_w[ST_PLL_LSB +: PLL_W] = pll_code_o;
      status_w[ST_HOLD_LSB +: HOLD_W] = pci_hold_o;
   end

   function automatic logic [DATA_W-1:0] rd_mux(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] st, ib, im, ob, om, mb);
      case (a)
         OFF_STATUS: rd_mux = st;
         OFF_IN_BASE: rd_mux = ib;
         OFF_IN_MASK: rd_mux = im;
         OFF_OUT_BASE: rd_mux = ob;
         OFF_OUT_MASK: rd_mux = om;
         OFF_MBOX: rd_mux = mb;
         default: rd_mux = WORD_RST;
      endcase
   endfunction

   // read values are selected ahead of the answer registers
   logic [DATA_W-1:0] reg_rd_val, pci_rd_val;
   logic pci_rd, pci_in_claim;
   assign reg_rd_val = rd_mux(reg_addr_i, status_w, in_base_r, in_mask_r, out_base_r, out_mask_r, mbox_r);
   assign pci_rd_val = rd_mux(pci_off, status_w, in_base_r, in_mask_r, out_base_r, out_mask_r, mbox_r);
   assign pci_rd = pci_allowed && !pci_wr_i;
   // inbound window hit claims the request as well
   assign pci_in_claim = pci_req_i && in_hit;

   // local writes win over a pci write in the same cycle
   logic [ADDR_W-1:0] wr_off;
   logic [DATA_W-1:0] wr_data;
   logic wr_en;
   assign wr_en = reg_wr_i || pci_reg_wr;
   assign wr_off = reg_wr_i ? reg_addr_i : pci_off;
   assign wr_data = reg_wr_i ? reg_wdata_i : pci_wdata_i;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         in_base_r <= WORD_RST;
         in_mask_r <= WORD_RST;
         out_base_r <= WORD_RST;
         out_mask_r <= WORD_RST;
         mbox_r <= WORD_RST;
      end else if (wr_en) begin
         case (wr_off)
            OFF_IN_BASE: in_base_r <= wr_data;
            OFF_IN_MASK: in_mask_r <= wr_data;
            OFF_OUT_BASE: out_base_r <= wr_data;
            OFF_OUT_MASK: out_mask_r <= wr_data;
            OFF_MBOX: mbox_r <= wr_data;
            default: ;
         endcase
      end
   end

   // ****************************************
   // answers, one cycle after the request
   // ****************************************
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= WORD_RST;
         pci_rdata_o <= WORD_RST;
         pci_ack_o <= 1'b0;
         pci_in_hit_o <= 1'b0;
         out_hit_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? reg_rd_val : WORD_RST;
         pci_rdata_o <= pci_rd ? pci_rd_val : WORD_RST;
         pci_ack_o <= pci_allowed || pci_in_claim;
         pci_in_hit_o <= pci_in_claim;
         out_hit_o <= out_req_i && out_hit;
      end
   end
endmodule // pms_bridge

// ### tb/pms_chk.sv
// assertion checker for the strap loader ports
`timescale 1ns/10ps
module pms_chk (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic hard_reset_in_n_i,
   input wire logic mem_addr4_strap_i,
   input wire logic cfg_valid_o,
   input wire logic host_mode_o,
   input wire logic [pms_pkg::PLL_W-1:0] pll_code_o,
   input wire logic [pms_pkg::HOLD_W-1:0] pci_hold_o,
   input wire logic pci_req_i,
   input wire logic pci_cfg_i,
   input wire logic pci_idsel_i,
   input wire logic [pms_pkg::DATA_W-1:0] pci_addr_i,
   input wire logic pci_ack_o,
   input wire logic out_req_i,
   input wire logic out_hit_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // memory request into the register block
   wire reg_hit = pci_req_i && !pci_cfg_i && pci_addr_i[31:12] == 20'h80000 && cfg_valid_o;
   property p_host_cfg; pci_req_i && pci_cfg_i && host_mode_o |=> !pci_ack_o; endproperty
   a_host_cfg: assert property (p_host_cfg) else $error("host cfg claimed");
   property p_agent_cfg; pci_req_i && pci_cfg_i && pci_idsel_i && !host_mode_o && cfg_valid_o |=> pci_ack_o;
   endproperty
   a_agent_cfg: assert property (p_agent_cfg) else $error("agent cfg missed");
   property p_host_std; reg_hit && host_mode_o && pci_addr_i[11:8] == 4'h0 |=> !pci_ack_o; endproperty
   a_host_std: assert property (p_host_std) else $error("host std reg claimed");
   property p_host_emb; reg_hit && host_mode_o && pci_addr_i[11:0] == 12'h100 |=> pci_ack_o; endproperty
   a_host_emb: assert property (p_host_emb) else $error("host mailbox missed");
   property p_out_host; out_req_i && host_mode_o |=> !out_hit_o; endproperty
   a_out_host: assert property (p_out_host) else $error("host outbound hit");
   property p_hold; $rose(cfg_valid_o) |-> pci_hold_o == (mem_addr4_strap_i ? 3'h6 : 3'h0); endproperty
   a_hold: assert property (p_hold) else $error("hold setting wrong");
   property p_keep; cfg_valid_o && $past(cfg_valid_o) |-> $stable(pll_code_o) && $stable(host_mode_o);
   endproperty
   a_keep: assert property (p_keep) else $error("captured straps moved");
   property p_hard; !hard_reset_in_n_i [*5] |=> !cfg_valid_o; endproperty
   a_hard: assert property (p_hard) else $error("valid during hard reset");
endmodule // pms_chk

// ### tb/pms_board.sv
// board strap logic and hard reset driver
`timescale 1ns/10ps
module pms_board (
   input wire logic m66_en_i,
   input wire logic hard_reset_req_i,
   output logic hard_reset_in_n_o,
   output logic [3:0] pll_code_o,
   output logic mem_addr4_strap_o,
   output logic [1:0] strap_drive_out_o
);
   assign hard_reset_in_n_o = !hard_reset_req_i;
   assign pll_code_o = m66_en_i ? 4'h0 : 4'h4;
   assign strap_drive_out_o = m66_en_i ? 2'h0 : 2'h3;
   assign mem_addr4_strap_o = strap_drive_out_o[0];
endmodule // pms_board

// ### tb/test_pms_bridge.sv
// self-checking bench for the strap loader
`timescale 1ns/10ps
module test_pms_bridge;
   import pms_pkg::*;
   logic clk_i = 0, resetn_i = 0, host = 1, m66 = 1, hr = 1;
   logic rd = 0, wr = 0, preq = 0, pcfg = 0, psel = 0, pwr = 0, oreq = 0;
   logic [11:0] ra = 0;
   logic [31:0] wd = 0, pa = 0, pd = 0, oa = 0;
   wire hrn, strap, valid, hm, ack, ihit, ohit;
   wire [3:0] pll, pllo;
   wire [2:0] hold;
   wire [31:0] rdat, prd;
   int fail_count = 0, samples_checked = 0;
   pms_board board (.m66_en_i(m66), .hard_reset_req_i(hr), .hard_reset_in_n_o(hrn), .pll_code_o(pll),
      .mem_addr4_strap_o(strap), .strap_drive_out_o());
   pms_bridge dut (.clk_i(clk_i), .resetn_i(resetn_i), .hard_reset_in_n_i(hrn), .host_mode_i(host),
      .pll_code_i(pll), .mem_addr4_strap_i(strap), .cfg_valid_o(valid), .host_mode_o(hm), .pll_code_o(pllo),
      .pci_hold_o(hold), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .pci_req_i(preq), .pci_cfg_i(pcfg), .pci_idsel_i(psel), .pci_wr_i(pwr), .pci_addr_i(pa),
      .pci_wdata_i(pd), .pci_ack_o(ack), .pci_in_hit_o(ihit), .pci_rdata_o(prd), .out_req_i(oreq),
      .out_addr_i(oa), .out_hit_o(ohit));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr <= w;
      rd <= !w;
      ra <= a;
      wd <= d;
      @(posedge clk_i);
      wr <= 0;
      rd <= 0;
      #1;
   endtask
   task automatic pci(input logic c, input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      preq <= 1;
      pcfg <= c;
      psel <= c && !host && a[16];
      pwr <= w;
      pa <= a;
      pd <= d;
      @(posedge clk_i);
      preq <= 0;
      #1;
   endtask
   task automatic outb(input logic [31:0] a);
      @(posedge clk_i);
      oreq <= 1;
      oa <= a;
      @(posedge clk_i);
      oreq <= 0;
      #1;
   endtask
   task automatic boot(input logic h, input logic m);
      @(posedge clk_i);
      hr <= 1;
      host <= h;
      m66 <= m;
      repeat (8) @(posedge clk_i);
      hr <= 0;
      repeat (8) @(posedge clk_i);
      acc(0, OFF_STATUS, 0);
      chk(rdat, {21'h0, m ? HOLD_FAST : HOLD_DEFAULT, m ? 4'h0 : 4'h4, 2'h0, 1'b1, h});
      chk(32'(hold), 32'(m ? HOLD_FAST : HOLD_DEFAULT));
      chk(32'(valid), 32'h1);
      chk(32'(hm), 32'(h));
      chk(32'(pllo), m ? 32'h0 : 32'h4);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #50000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      resetn_i <= 1;
      boot(1, 1);
      pci(1, 1, 32'h0001_0004, 32'h1);
      chk(32'(ack), 32'h0);
      pci(0, 0, REG_BAR, 0);
      chk(32'(ack), 32'h0);
      pci(0, 1, REG_BAR | 32'h100, 32'h5a5a_0001);
      chk(32'(ack), 32'h1);
      pci(0, 0, REG_BAR | 32'h100, 0);
      chk(prd, 32'h5a5a_0001);
      acc(1, OFF_OUT_BASE, 32'h4000_0001);
      acc(1, OFF_OUT_MASK, 32'hf000_0000);
      outb(32'h4000_0010);
      chk(32'(ohit), 32'h0);
      $display("host mode test done");
      boot(0, 0);
      pci(1, 1, 32'h0001_000c, 32'h4000_0001);
      chk(32'(ack), 32'h1);
      pci(1, 1, 32'h0001_0010, 32'hf000_0000);
      pci(1, 1, 32'h0001_0004, 32'h2000_0001);
      pci(1, 1, 32'h0001_0008, 32'hf000_0000);
      outb(32'h4123_4567);
      chk(32'(ohit), 32'h1);
      outb(32'h5000_0000);
      chk(32'(ohit), 32'h0);
      pci(0, 0, 32'h2000_0010, 0);
      chk(32'(ihit), 32'h1);
      pci(0, 0, REG_BAR, 0);
      chk(prd, 32'h0000_0642);
      acc(0, 12'h020, 0);
      chk(rdat, 32'h0);
      @(posedge clk_i);
      m66 <= 1;
      repeat (8) @(posedge clk_i);
      #1;
      chk(32'(pllo), 32'h4);
      chk(32'(hold), 32'(HOLD_DEFAULT));
      $display("agent mode test done");
      report_and_stop();
   end
endmodule // test_pms_bridge
bind pms_bridge pms_chk chk (.clk_i, .resetn_i, .hard_reset_in_n_i, .mem_addr4_strap_i, .cfg_valid_o,
   .host_mode_o, .pll_code_o, .pci_hold_o, .pci_req_i, .pci_cfg_i, .pci_idsel_i, .pci_addr_i, .pci_ack_o,
   .out_req_i, .out_hit_o);
